// ### hw/sere_engine.sv
// two-wire serial eeprom engine: page write, ack polling, protect, reads
// Summary of operation
// - page write takes up to sixteen bytes
// - ack each data byte, bump low offset
// - page select bits stay fixed during writes
// - offset wraps in page, newer bytes overwrite
// - nonvolatile write starts only after stop
// - busy device does not acknowledge poll
// - idle device acknowledges poll, host continues
// - protect pin high blocks all array writes
// - protect low or open changes nothing
// - protect sampled just before first data byte
// - protected write: no data ack, request dropped
// - array starts erased to all ones
// - read address: ack, send current byte
// - master nack then stop ends read
// - random read returns addressed byte, master nacks
// - master ack keeps sequential bytes coming
// - read address wraps only at memory end
// - address byte: one, select, upper, direction
// - busy device releases data, ignores requests
// - ack by pulling data low, ninth clock
`timescale 1ns/1ps
`include "sere_defs.svh"
module sere_engine #(
  parameter int WR_CYCLES = `SERE_WR_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  input  wire logic       wp_in,
  input  wire logic [2:0] cascade_select_inputs,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            write_busy
);
  localparam int AW = `SERE_ADDR_W;

  // bus condition detectors: sda acts as the clock, scl as the qualifier
  logic start_tgl_reg = 1'b0;
  logic stop_tgl_reg  = 1'b0;

  always_ff @(negedge sda_in) begin
    if (scl_clk) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_ff @(posedge sda_in) begin
    if (scl_clk) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end

  // ---------------- link domain (scl) ----------------
  logic                 scl_rst;
  logic [4:0]           scl_in_s;
  logic                 busy_s;
  logic                 wp_s;
  logic [2:0]           sel_s;
  sere_pkg::sere_state_e state_reg;
  logic [3:0]           bit_cnt_reg;
  logic [7:0]           shift_reg;
  logic [7:0]           byte_w;
  logic [AW-1:0]        addr_reg;
  logic                 ack_reg;
  logic                 wp_lat_reg;
  logic                 pending_reg;
  logic                 start_cpy_reg;
  logic                 start_seen;
  logic                 stop_cpy_reg;
  logic                 stop_seen;
  logic                 wr_addr_ack;
  logic                 dev_match;
  logic                 at_last;
  logic                 at_ack;
  logic                 wr_ok;
  logic [`SERE_PAGE_BYTES-1:0] mask_reg;
  logic [7:0]           page_buf [`SERE_PAGE_BYTES];
  logic [7:0]           rd_byte;
  logic [7:0]           mem_reg [`SERE_MEM_BYTES] = '{default: `SERE_ERASED};

  sere_sync #(.W(1)) u_rst_scl (
    .clk (scl_clk),
    .d   (sys_rst),
    .q   (scl_rst)
  );

  sere_sync #(.W(5)) u_pins_scl (
    .clk (scl_clk),
    .d   ({write_busy, wp_in, cascade_select_inputs}),
    .q   (scl_in_s)
  );

  assign busy_s = scl_in_s[4];
  assign wp_s   = scl_in_s[3];
  assign sel_s  = scl_in_s[2:0];

  assign start_seen = start_tgl_reg ^ start_cpy_reg;
  assign stop_seen  = stop_tgl_reg ^ stop_cpy_reg;
  assign wr_addr_ack = state_reg == sere_pkg::ST_DEVADDR && at_ack && ack_reg &&
                       !shift_reg[`SERE_SA_RW_BIT];
  assign byte_w     = {shift_reg[6:0], sda_in};
  assign at_last    = bit_cnt_reg == `SERE_BIT_LAST;
  assign at_ack     = bit_cnt_reg == `SERE_BIT_ACK;
  // select bits compared with the middle pin inverted
  assign dev_match  = (byte_w[`SERE_SA_FIX_BIT] == `SERE_SA_FIX_VAL) &&
                      (byte_w[`SERE_SA_SEL_HI:`SERE_SA_SEL_LO] ==
                       (sel_s ^ `SERE_SEL_INV_MASK));
  // a protected write never reaches the buffer; low protect is a no-op
  assign wr_ok      = state_reg == sere_pkg::ST_WRDATA && at_last && !wp_lat_reg;
  // array read for the link; stable because writes only happen at the commit after stop
  assign rd_byte    = mem_reg[addr_reg];

  always_ff @(posedge scl_clk) begin
    if (scl_rst) begin
      start_cpy_reg <= 1'b0;
      stop_cpy_reg  <= 1'b0;
    end else begin
      start_cpy_reg <= start_tgl_reg;
      stop_cpy_reg  <= stop_tgl_reg;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (scl_rst) begin
      state_reg   <= sere_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (start_seen) begin
      state_reg   <= sere_pkg::ST_DEVADDR;
      bit_cnt_reg <= `SERE_BIT_FIRST;
    end else if (state_reg != sere_pkg::ST_IDLE && state_reg != sere_pkg::ST_IGNORE) begin
      if (at_ack) begin
        bit_cnt_reg <= 4'h0;
        unique case (state_reg)
          sere_pkg::ST_DEVADDR: begin
            if (!ack_reg) begin
              state_reg <= sere_pkg::ST_IGNORE;
            end else if (shift_reg[`SERE_SA_RW_BIT]) begin
              state_reg <= sere_pkg::ST_RDDATA;
            end else begin
              state_reg <= sere_pkg::ST_WORDADDR;
            end
          end
          sere_pkg::ST_WORDADDR: begin
            state_reg <= sere_pkg::ST_WRDATA;
          end
          sere_pkg::ST_WRDATA: begin
            state_reg <= ack_reg ? sere_pkg::ST_WRDATA : sere_pkg::ST_IGNORE;
          end
          sere_pkg::ST_RDDATA: begin
            // master ack keeps the stream going, nack parks until start
            state_reg <= sda_in ? sere_pkg::ST_IGNORE : sere_pkg::ST_RDDATA;
          end
          sere_pkg::ST_IDLE, sere_pkg::ST_IGNORE: begin
            state_reg <= state_reg;
          end
        endcase
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge scl_clk) begin
    if (scl_rst) begin
      shift_reg <= 8'h00;
    end else if (start_seen) begin
      shift_reg <= {7'h00, sda_in};
    end else if (!at_ack) begin
      shift_reg <= byte_w;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (scl_rst || start_seen) begin
      ack_reg <= 1'b0;
    end else if (at_last) begin
      unique case (state_reg)
        sere_pkg::ST_DEVADDR:  ack_reg <= dev_match && !busy_s;
        sere_pkg::ST_WORDADDR: ack_reg <= 1'b1;
        sere_pkg::ST_WRDATA:   ack_reg <= !wp_lat_reg;
        default:               ack_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (scl_rst) begin
      addr_reg <= '0;
    end else if (state_reg == sere_pkg::ST_DEVADDR && at_last && dev_match && !busy_s) begin
      addr_reg[`SERE_ADDR_HI:`SERE_UP_LO] <= byte_w[`SERE_SA_UP_HI:`SERE_SA_UP_LO];
    end else if (state_reg == sere_pkg::ST_WORDADDR && at_last) begin
      addr_reg[`SERE_LOW_HI:0] <= byte_w;
    end else if (wr_ok) begin
      // only the in-page offset moves, so a long burst wraps in the page
      addr_reg[`SERE_OFS_HI:0] <= addr_reg[`SERE_OFS_HI:0] + 4'h1;
    end else if (state_reg == sere_pkg::ST_RDDATA && at_ack) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (scl_rst) begin
      wp_lat_reg <= 1'b0;
    end else if (state_reg == sere_pkg::ST_WORDADDR && at_ack) begin
      wp_lat_reg <= wp_s;
    end
  end

  // repeated start cancels an open write; after stop the page waits for commit
  always_ff @(posedge scl_clk) begin
    if (scl_rst || (start_seen && !stop_seen) || wr_addr_ack) begin
      pending_reg <= 1'b0;
      mask_reg    <= '0;
    end else if (wr_ok) begin
      pending_reg                      <= 1'b1;
      mask_reg[addr_reg[`SERE_OFS_HI:0]] <= 1'b1;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (wr_ok) begin
      page_buf[addr_reg[`SERE_OFS_HI:0]] <= byte_w;
    end
  end

  always_ff @(negedge scl_clk) begin
    if (scl_rst) begin
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (at_ack && ack_reg && state_reg != sere_pkg::ST_RDDATA) begin
        sda_oe_n <= 1'b0;
      end else if (state_reg == sere_pkg::ST_RDDATA && !at_ack) begin
        sda_oe_n <= rd_byte[3'(`SERE_BIT_LAST - bit_cnt_reg)];
      end else begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // ---------------- system domain ----------------
  logic [1:0] sys_in_s;
  logic       stop_prev_reg;
  logic       stop_evt;
  logic       commit;
  logic       commit_done_reg;

  sere_sync #(.W(2)) u_link_sys (
    .clk (clk_sys),
    .d   ({stop_tgl_reg, pending_reg}),
    .q   (sys_in_s)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stop_prev_reg <= sys_in_s[1];
    end else begin
      stop_prev_reg <= sys_in_s[1];
    end
  end

  // later stops from refused polls must not write the held page again
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !sys_in_s[0]) begin
      commit_done_reg <= 1'b0;
    end else if (commit) begin
      commit_done_reg <= 1'b1;
    end
  end
  assign stop_evt = sys_in_s[1] ^ stop_prev_reg;
  assign commit   = stop_evt && sys_in_s[0] && !write_busy && !commit_done_reg;

  sere_timer #(.CYCLES(WR_CYCLES)) u_timer (
    .clk   (clk_sys),
    .rst   (sys_rst),
    .start (commit),
    .busy  (write_busy)
  );

  // buffer, mask and page are quiet here: the link is halted after stop
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      for (int i = 0; i < `SERE_PAGE_BYTES; i++) begin
        if (mask_reg[i]) begin
          mem_reg[{addr_reg[`SERE_ADDR_HI:`SERE_PAGE_LO], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // ---------------- checks ----------------
  property p_page_step;
    @(posedge scl_clk) disable iff (scl_rst)
    (wr_ok && !start_seen) |=>
      (addr_reg[`SERE_OFS_HI:0] == $past(addr_reg[`SERE_OFS_HI:0]) + 4'h1) &&
      (addr_reg[`SERE_ADDR_HI:`SERE_PAGE_LO] == $past(addr_reg[`SERE_ADDR_HI:`SERE_PAGE_LO]));
  endproperty
  a_page_step: assert property (p_page_step) else $error("page offset step wrong");

  property p_wp_reject;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_WRDATA && at_last && wp_lat_reg && !start_seen && !pending_reg)
      |=> (!ack_reg && !pending_reg) ##1 (state_reg == sere_pkg::ST_IGNORE);
  endproperty
  a_wp_reject: assert property (p_wp_reject) else $error("protected write accepted");

  property p_wp_sample;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_WORDADDR && at_ack && !start_seen)
      |=> (wp_lat_reg == $past(wp_s)) && (state_reg == sere_pkg::ST_WRDATA);
  endproperty
  a_wp_sample: assert property (p_wp_sample) else $error("protect not sampled");

  property p_busy_nack;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_DEVADDR && at_last && busy_s && !start_seen)
      |=> !ack_reg ##1 (state_reg == sere_pkg::ST_IGNORE || start_seen);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("busy device acknowledged");

  property p_idle_ack;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_DEVADDR && at_last && dev_match && !busy_s && !start_seen)
      |=> ack_reg;
  endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("poll not acknowledged");

  property p_ack_drive;
    @(posedge scl_clk) disable iff (scl_rst)
    (at_ack && ack_reg && state_reg != sere_pkg::ST_RDDATA) |-> !sda_oe_n;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_read_bit;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_RDDATA && !at_ack && !$past(start_seen))
      |-> sda_oe_n == rd_byte[3'(`SERE_BIT_LAST - bit_cnt_reg)];
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read bit mismatch");

  property p_read_inc;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_RDDATA && at_ack && !start_seen)
      |=> addr_reg == $past(addr_reg) + 1'b1;
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read address not advanced");

  property p_read_end;
    @(posedge scl_clk) disable iff (scl_rst)
    (state_reg == sere_pkg::ST_RDDATA && at_ack && !start_seen)
      |=> (state_reg == ($past(sda_in) ? sere_pkg::ST_IGNORE : sere_pkg::ST_RDDATA));
  endproperty
  a_read_end: assert property (p_read_end) else $error("read stream control wrong");

  property p_commit_at_stop;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(write_busy) |-> $past(stop_evt && sys_in_s[0]);
  endproperty
  a_commit_at_stop: assert property (p_commit_at_stop) else $error("write began without stop");
endmodule

// ### hw/sere_defs.svh
// shared constants for the serial eeprom command engine
`ifndef SERE_DEFS_SVH
`define SERE_DEFS_SVH

`define SERE_ADDR_W       11
`define SERE_MEM_BYTES    2048
`define SERE_PAGE_BYTES   16
`define SERE_OFS_W        4
`define SERE_ERASED       8'hFF

// address split
`define SERE_ADDR_HI      10
`define SERE_UP_LO        8
`define SERE_LOW_HI       7
`define SERE_OFS_HI       3
`define SERE_PAGE_LO      4

// slave address byte layout
`define SERE_SA_FIX_BIT   7
`define SERE_SA_FIX_VAL   1'b1
`define SERE_SA_SEL_HI    6
`define SERE_SA_SEL_LO    4
`define SERE_SA_UP_HI     3
`define SERE_SA_UP_LO     1
`define SERE_SA_RW_BIT    0
`define SERE_SEL_INV_MASK 3'h2

// bit counter within a byte slot
`define SERE_BIT_FIRST    4'h1
`define SERE_BIT_LAST     4'h7
`define SERE_BIT_ACK      4'h8

// timing
`define SERE_CLK_HZ                 10000000
`define SERE_INTERNAL_WRITE_TIME_MS 5
`define SERE_WR_CYCLES ((`SERE_INTERNAL_WRITE_TIME_MS * `SERE_CLK_HZ) / 1000)

`endif

// ### hw/sere_pkg.sv
// types for the serial eeprom command engine
package sere_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_WORDADDR,
    ST_WRDATA,
    ST_RDDATA,
    ST_IGNORE
  } sere_state_e;
endpackage

// ### hw/sere_sync.sv
// two-stage level synchroniser
`timescale 1ns/1ps
module sere_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
  end

  always_ff @(posedge clk) begin
    q <= meta_reg;
  end
endmodule

// ### hw/sere_timer.sv
// internal write cycle timer
`timescale 1ns/1ps
module sere_timer #(
  parameter int CYCLES = 50000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      cnt_reg <= '0;
    end else if (start && !busy) begin
      busy    <= 1'b1;
      cnt_reg <= CNT_W'(CYCLES - 1);
    end else if (busy) begin
      if (cnt_reg == '0) begin
        busy <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  property p_timer_load;
    @(posedge clk) disable iff (rst)
    (start && !busy) |=> (busy && cnt_reg == CNT_W'(CYCLES - 1));
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("write timer not loaded");

  property p_timer_end;
    @(posedge clk) disable iff (rst)
    (busy && cnt_reg == '0) |=> !busy;
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("write cycle overran");
endmodule

// ### verification/sere_bus_master.sv
// two-wire bus master model facing the serial eeprom engine
`timescale 1ns/1ps
module sere_bus_master (
  output logic      scl,
  output logic      sda_oe_n,
  input  wire logic sda
);
  // bus idles with clock high and data released; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // clocks with data released, only around reset so no start or stop is seen
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #32 scl = 1'b0;
      #32 scl = 1'b1;
    end
  endtask

  // data moves a little after the falling clock so it never races the start detector
  task automatic start_cond();
    #8 sda_oe_n = 1'b1;
    #8 scl = 1'b1;
    #16 sda_oe_n = 1'b0;
    #32 scl = 1'b0;
  endtask

  task automatic stop_cond();
    #8 sda_oe_n = 1'b0;
    #24 scl = 1'b1;
    #32 sda_oe_n = 1'b1;
    #32;
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    #8 sda_oe_n = b;
    #24 scl = 1'b1;
    #24 r = sda;
    #8 scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, ack_n);
  endtask

  // ack_n high on the last byte ends a read
  task automatic recv_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(ack_n, r);
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the serial eeprom engine with a bus master model
`timescale 1ns/1ps
module tb;
  localparam int WR    = 40;
  localparam int LIMIT = 40000;
  logic        clk_sys    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        wp_in      = 1'b0;
  logic [2:0]  sel        = 3'h0;
  logic        scl;
  logic        m_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        write_busy;
  wire         sda;
  logic [7:0]  mem [0:2047];
  logic [31:0] seed       = 32'h7E416092;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          cycles     = 0;

  // pull-up wire: low when either party pulls
  assign sda = m_oe_n & (sda_oe_n | sda_out);
  always #50 clk_sys = ~clk_sys;

  sere_engine #(.WR_CYCLES(WR)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_clk(scl), .sda_in(sda), .wp_in(wp_in),
    .cascade_select_inputs(sel), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_busy(write_busy));
  sere_bus_master m (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] dev_addr(input logic [10:0] a, input logic rw);
    return {1'b1, sel[2], ~sel[1], sel[0], a[10:8], rw};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic write_seq(input logic [10:0] a, input int n, input logic prot);
    logic       k;
    logic [7:0] d;
    m.start_cond();
    m.send_byte(dev_addr(a, 1'b0), k);
    check("write addr ack", 8'(k), 8'h00);
    m.send_byte(a[7:0], k);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      m.send_byte(d, k);
      check("data ack", 8'(k), 8'(prot));
      if (!prot) mem[a] = d;
      a[3:0] = a[3:0] + 4'h1;
    end
    check("busy before stop", 8'(write_busy), 8'h00);
    m.stop_cond();
  endtask

  // polls with a write address, then carries on as a random read
  task automatic read_seq(input logic [10:0] a, input int n, input logic poll);
    logic       k;
    logic [7:0] d;
    int         tries;
    tries = 0;
    k = 1'b1;
    while (k && tries < 30) begin
      m.start_cond();
      m.send_byte(dev_addr(a, 1'b0), k);
      if (k) m.stop_cond();
      tries++;
    end
    if (poll) check("poll refused while busy", 8'(tries > 1), 8'h01);
    check("poll ack", 8'(k), 8'h00);
    m.send_byte(a[7:0], k);
    m.start_cond();
    m.send_byte(dev_addr(a, 1'b1), k);
    check("read addr ack", 8'(k), 8'h00);
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i == n - 1, d);
      check("read data", d, mem[a]);
      a = a + 11'h001;
    end
    m.stop_cond();
  endtask

  task automatic cur_read(input logic [10:0] a);
    logic       k;
    logic [7:0] d;
    m.start_cond();
    m.send_byte(dev_addr(a, 1'b1), k);
    m.recv_byte(1'b1, d);
    m.stop_cond();
    check("current read", d, mem[a]);
  endtask

  initial begin
    logic [10:0] a;
    logic        k;
    int          n;
    for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
    sel = 3'(rnd());
    fork
      m.idle_clocks(20);
      begin
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
      end
    join
    a = 11'(rnd());
    read_seq(a, 2, 1'b0);
    // another device's select must be ignored
    m.start_cond();
    m.send_byte(dev_addr(a, 1'b0) ^ 8'h20, k);
    m.stop_cond();
    check("foreign select nack", 8'(k), 8'h01);
    // eighteen bytes wrap inside the page and overwrite the first two
    a = 11'(rnd());
    write_seq(a, 18, 1'b0);
    read_seq({a[10:4], 4'h0}, 16, 1'b1);
    // protected write leaves the array alone and starts no cycle
    @(negedge clk_sys);
    wp_in = 1'b1;
    write_seq(a, 1, 1'b1);
    repeat (10) @(negedge clk_sys);
    check("busy after protected write", 8'(write_busy), 8'h00);
    wp_in = 1'b0;
    read_seq(a, 1, 1'b0);
    repeat (4) begin
      a = 11'(rnd());
      n = 1 + int'(rnd() % 16);
      write_seq(a, n, 1'b0);
      read_seq({a[10:4], 4'h0}, 16, 1'b1);
    end
    // sequential read across the end of memory, then a current read follows on
    write_seq(11'h7FE, 2, 1'b0);
    read_seq(11'h7FE, 4, 1'b1);
    cur_read(11'h002);
    complete_run();
  end
endmodule
